// ===== verilog/dtc_pkg.sv
// Package for the dual timer control and mode block: offsets, fields, modes and carrier types.
package dtc_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h88;
  localparam logic [7:0] TIMER_MODE_ADDR    = 8'h89;
  localparam logic [7:0] TIMER_A_LOW_ADDR   = 8'h8a;
  localparam logic [7:0] TIMER_B_LOW_ADDR   = 8'h8b;
  localparam logic [7:0] TIMER_A_HIGH_ADDR  = 8'h8c;
  localparam logic [7:0] TIMER_B_HIGH_ADDR  = 8'h8d;
  localparam logic [7:0] REG_RESET          = 8'h00;
  localparam logic [7:0] BYTE_ONES          = 8'hff;
  localparam logic [7:0] BYTE_ONE           = 8'h01;
  localparam logic [3:0] PIN_IDLE           = 4'hf;
  localparam int         PIN_COUNT          = 4;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int CTL_B_OVF  = 7;
  localparam int CTL_B_RUN  = 6;
  localparam int CTL_A_OVF  = 5;
  localparam int CTL_A_RUN  = 4;
  localparam int CTL_XB_PND = 3;
  localparam int CTL_XB_EDG = 2;
  localparam int CTL_XA_PND = 1;
  localparam int CTL_XA_EDG = 0;

  // ==========================================================================
  // Mode register fields: timer B in the upper nibble, timer A in the lower.
  // ==========================================================================
  localparam int MOD_B_LSB  = 4;
  localparam int MOD_A_LSB  = 0;
  localparam int MOD_GATE   = 3;
  localparam int MOD_CNT    = 2;
  localparam int MOD_SEL_HI = 1;
  localparam int MOD_SEL_LO = 0;

  // ==========================================================================
  // Prescaler and timing
  // ==========================================================================
  localparam logic [4:0] PRESCALE_ONES  = 5'h1f;
  localparam logic [4:0] PRESCALE_ONE   = 5'h01;
  localparam int         PER_DIV        = 6;
  localparam logic [2:0] PER_DIV_LAST   = 3'(PER_DIV - 1);
  localparam logic [2:0] PER_DIV_ZERO   = 3'h0;
  localparam logic [2:0] PER_DIV_STEP   = 3'h1;

  typedef enum logic [1:0] {
    DTC_MODE_PRESCALED = 2'b00,
    DTC_MODE_CASCADE   = 2'b01,
    DTC_MODE_RELOAD    = 2'b10,
    DTC_MODE_SPLIT     = 2'b11
  } dtc_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dtc_bus_req_t;

  // Per timer control bits taken from the mode register nibble.
  typedef struct packed {
    logic      gate;
    logic      cnt;
    dtc_mode_t mode;
  } dtc_tmode_t;

endpackage : dtc_pkg

// ===== verilog/dtc_timer_ctrl.sv
// Dual timer control and mode registers with the two count datapaths they steer.
`timescale 1ns/100ps
module dtc_timer_ctrl (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_ce,
  input  wire dtc_pkg::dtc_bus_req_t i_bus,
  output logic [7:0]                 o_rdata,
  input  wire logic                  i_ext_irq_a_pin,
  input  wire logic                  i_ext_irq_b_pin,
  input  wire logic                  i_timer_a_count_pin,
  input  wire logic                  i_timer_b_count_pin,
  input  wire logic                  i_vector_timer_a,
  input  wire logic                  i_vector_timer_b,
  input  wire logic                  i_vector_ext_a,
  input  wire logic                  i_vector_ext_b,
  output logic                       o_timer_a_irq,
  output logic                       o_timer_b_irq,
  output logic                       o_ext_irq_a_req,
  output logic                       o_ext_irq_b_req
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Order: irq a, irq b, count a, count b. Stage 1 feeds only stage 2.
  logic [3:0] pin_raw;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] sync3_ff;
  logic [3:0] pin_lvl_ff;
  logic [3:0] pin_prev_ff;
  logic [3:0] pin_fall;

  assign pin_raw = {i_timer_b_count_pin, i_timer_a_count_pin, i_ext_irq_b_pin, i_ext_irq_a_pin};

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync1_ff    <= dtc_pkg::PIN_IDLE;
      sync2_ff    <= dtc_pkg::PIN_IDLE;
      sync3_ff    <= dtc_pkg::PIN_IDLE;
      pin_lvl_ff  <= dtc_pkg::PIN_IDLE;
      pin_prev_ff <= dtc_pkg::PIN_IDLE;
    end else if (i_ce) begin
      sync1_ff    <= pin_raw;
      sync2_ff    <= sync1_ff;
      sync3_ff    <= sync2_ff;
      // A change is accepted only once stages two and three agree.
      for (int i = 0; i < dtc_pkg::PIN_COUNT; i++) begin
        if (sync2_ff[i] == sync3_ff[i]) begin
          pin_lvl_ff[i] <= sync3_ff[i];
        end
      end
      pin_prev_ff <= pin_lvl_ff;
    end
  end

  assign pin_fall = pin_prev_ff & ~pin_lvl_ff;

  // ==========================================================================
  // Register bus
  // ==========================================================================
  logic [7:0] ctl_ff;
  logic [7:0] mod_ff;
  logic [7:0] a_lo_ff;
  logic [7:0] a_hi_ff;
  logic [7:0] b_lo_ff;
  logic [7:0] b_hi_ff;

  function automatic logic hit(input dtc_pkg::dtc_bus_req_t req, input logic [7:0] adr);
    hit = req.wr && (req.addr == adr);
  endfunction : hit

  function automatic dtc_pkg::dtc_tmode_t nib(input logic [3:0] n);
    nib = dtc_pkg::dtc_tmode_t'(n);
  endfunction : nib

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= dtc_pkg::REG_RESET;
    end else if (i_ce) begin
      o_rdata <= dtc_pkg::REG_RESET;
      if (i_bus.rd) begin
        unique case (i_bus.addr)
          dtc_pkg::TIMER_CONTROL_ADDR: o_rdata <= ctl_ff;
          dtc_pkg::TIMER_MODE_ADDR:    o_rdata <= mod_ff;
          dtc_pkg::TIMER_A_LOW_ADDR:   o_rdata <= a_lo_ff;
          dtc_pkg::TIMER_B_LOW_ADDR:   o_rdata <= b_lo_ff;
          dtc_pkg::TIMER_A_HIGH_ADDR:  o_rdata <= a_hi_ff;
          dtc_pkg::TIMER_B_HIGH_ADDR:  o_rdata <= b_hi_ff;
          default:                     o_rdata <= dtc_pkg::REG_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mod_ff <= dtc_pkg::REG_RESET;
    end else if (i_ce && hit(i_bus, dtc_pkg::TIMER_MODE_ADDR)) begin
      mod_ff <= i_bus.wdata;
    end
  end

  // ==========================================================================
  // Count enables
  // ==========================================================================
  dtc_pkg::dtc_tmode_t ma;
  dtc_pkg::dtc_tmode_t mb;
  logic [2:0] div_ff;
  logic       tick_div;
  logic       a_split;
  logic       a_run_en;
  logic       b_run_en;
  logic       a_step;
  logic       b_step;
  logic       ah_step;

  assign ma      = nib(mod_ff[dtc_pkg::MOD_A_LSB +: 4]);
  assign mb      = nib(mod_ff[dtc_pkg::MOD_B_LSB +: 4]);
  assign a_split = (ma.mode == dtc_pkg::DTC_MODE_SPLIT);

  // Peripheral clock divided by six gives the timer tick.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      div_ff <= dtc_pkg::PER_DIV_ZERO;
    end else if (i_ce) begin
      div_ff <= (div_ff == dtc_pkg::PER_DIV_LAST) ? dtc_pkg::PER_DIV_ZERO : div_ff + dtc_pkg::PER_DIV_STEP;
    end
  end
  assign tick_div = (div_ff == dtc_pkg::PER_DIV_LAST);

  assign a_run_en = ctl_ff[dtc_pkg::CTL_A_RUN] && (!ma.gate || pin_lvl_ff[0]);
  assign b_run_en = ctl_ff[dtc_pkg::CTL_B_RUN] && (!mb.gate || pin_lvl_ff[1]);
  // Counter select takes falling pin edges, else the divided clock.
  assign a_step   = a_run_en && (ma.cnt ? pin_fall[2] : tick_div);
  // In split mode timer B loses its run bit, so mode 11 is its only stop.
  assign b_step   = (a_split ? 1'b1 : b_run_en) && (mb.mode != dtc_pkg::DTC_MODE_SPLIT)
                    && (mb.cnt ? pin_fall[3] : tick_div);
  assign ah_step  = a_split && ctl_ff[dtc_pkg::CTL_B_RUN] && tick_div;

  // ==========================================================================
  // Count datapaths
  // ==========================================================================
  logic a_ovf;
  logic b_ovf;
  logic ah_ovf;
  logic [7:0] nxt_a_lo;
  logic [7:0] nxt_a_hi;
  logic [7:0] nxt_b_lo;
  logic [7:0] nxt_b_hi;

  // Shared step for one timer in all four modes; in mode 11 only the low byte, the caller steps the high byte.
  task automatic step_timer(input logic [1:0] mode, input logic [7:0] lo, input logic [7:0] hi,
                            output logic [7:0] nlo, output logic [7:0] nhi, output logic ovf);
    nlo = lo;
    nhi = hi;
    ovf = 1'b0;
    unique case (mode)
      dtc_pkg::DTC_MODE_PRESCALED: begin
        nlo[4:0] = lo[4:0] + dtc_pkg::PRESCALE_ONE;
        if (lo[4:0] == dtc_pkg::PRESCALE_ONES) begin
          nhi = hi + dtc_pkg::BYTE_ONE;
          ovf = (hi == dtc_pkg::BYTE_ONES);
        end
      end
      dtc_pkg::DTC_MODE_CASCADE: begin
        nlo = lo + dtc_pkg::BYTE_ONE;
        if (lo == dtc_pkg::BYTE_ONES) begin
          nhi = hi + dtc_pkg::BYTE_ONE;
          ovf = (hi == dtc_pkg::BYTE_ONES);
        end
      end
      dtc_pkg::DTC_MODE_RELOAD: begin
        nlo = (lo == dtc_pkg::BYTE_ONES) ? hi : lo + dtc_pkg::BYTE_ONE;
        ovf = (lo == dtc_pkg::BYTE_ONES);
      end
      dtc_pkg::DTC_MODE_SPLIT: begin
        nlo = lo + dtc_pkg::BYTE_ONE;
        ovf = (lo == dtc_pkg::BYTE_ONES);
      end
    endcase
  endtask : step_timer

  always_comb begin
    nxt_a_lo = a_lo_ff;
    nxt_a_hi = a_hi_ff;
    nxt_b_lo = b_lo_ff;
    nxt_b_hi = b_hi_ff;
    a_ovf    = 1'b0;
    b_ovf    = 1'b0;
    ah_ovf   = 1'b0;
    if (a_step) begin
      step_timer(ma.mode, a_lo_ff, a_hi_ff, nxt_a_lo, nxt_a_hi, a_ovf);
    end
    if (a_split) begin
      nxt_a_hi = a_hi_ff;
      if (ah_step) begin
        nxt_a_hi = a_hi_ff + dtc_pkg::BYTE_ONE;
        ah_ovf   = (a_hi_ff == dtc_pkg::BYTE_ONES);
      end
    end
    if (b_step) begin
      step_timer(mb.mode, b_lo_ff, b_hi_ff, nxt_b_lo, nxt_b_hi, b_ovf);
    end
  end

  // Software writes to a count byte win over the count in that cycle.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      a_lo_ff <= dtc_pkg::REG_RESET;
      a_hi_ff <= dtc_pkg::REG_RESET;
      b_lo_ff <= dtc_pkg::REG_RESET;
      b_hi_ff <= dtc_pkg::REG_RESET;
    end else if (i_ce) begin
      a_lo_ff <= hit(i_bus, dtc_pkg::TIMER_A_LOW_ADDR)  ? i_bus.wdata : nxt_a_lo;
      a_hi_ff <= hit(i_bus, dtc_pkg::TIMER_A_HIGH_ADDR) ? i_bus.wdata : nxt_a_hi;
      b_lo_ff <= hit(i_bus, dtc_pkg::TIMER_B_LOW_ADDR)  ? i_bus.wdata : nxt_b_lo;
      b_hi_ff <= hit(i_bus, dtc_pkg::TIMER_B_HIGH_ADDR) ? i_bus.wdata : nxt_b_hi;
    end
  end

  // ==========================================================================
  // Control register
  // ==========================================================================
  logic [7:0] nxt_ctl;
  logic       xa_det;
  logic       xb_det;

  // Edge mode catches falling edges; level mode follows the low pin.
  assign xa_det = ctl_ff[dtc_pkg::CTL_XA_EDG] ? pin_fall[0] : !pin_lvl_ff[0];
  assign xb_det = ctl_ff[dtc_pkg::CTL_XB_EDG] ? pin_fall[1] : !pin_lvl_ff[1];

  always_comb begin
    nxt_ctl = ctl_ff;
    if (hit(i_bus, dtc_pkg::TIMER_CONTROL_ADDR)) begin
      nxt_ctl = i_bus.wdata;
    end
    // Hardware clears come first so a coincident event still sets the flag.
    if (i_vector_timer_a) begin
      nxt_ctl[dtc_pkg::CTL_A_OVF] = 1'b0;
    end
    if (i_vector_timer_b) begin
      nxt_ctl[dtc_pkg::CTL_B_OVF] = 1'b0;
    end
    if (i_vector_ext_a && ctl_ff[dtc_pkg::CTL_XA_EDG]) begin
      nxt_ctl[dtc_pkg::CTL_XA_PND] = 1'b0;
    end
    if (i_vector_ext_b && ctl_ff[dtc_pkg::CTL_XB_EDG]) begin
      nxt_ctl[dtc_pkg::CTL_XB_PND] = 1'b0;
    end
    if (a_ovf) begin
      nxt_ctl[dtc_pkg::CTL_A_OVF] = 1'b1;
    end
    // In split mode the timer A high byte owns this flag, so timer B's own roll is silent.
    if ((b_ovf && !a_split) || ah_ovf) begin
      nxt_ctl[dtc_pkg::CTL_B_OVF] = 1'b1;
    end
    if (xa_det) begin
      nxt_ctl[dtc_pkg::CTL_XA_PND] = 1'b1;
    end
    if (xb_det) begin
      nxt_ctl[dtc_pkg::CTL_XB_PND] = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctl_ff <= dtc_pkg::REG_RESET;
    end else if (i_ce) begin
      ctl_ff <= nxt_ctl;
    end
  end

  // ==========================================================================
  // Request outputs
  // ==========================================================================
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_timer_a_irq   <= 1'b0;
      o_timer_b_irq   <= 1'b0;
      o_ext_irq_a_req <= 1'b0;
      o_ext_irq_b_req <= 1'b0;
    end else if (i_ce) begin
      o_timer_a_irq   <= nxt_ctl[dtc_pkg::CTL_A_OVF];
      o_timer_b_irq   <= nxt_ctl[dtc_pkg::CTL_B_OVF];
      o_ext_irq_a_req <= nxt_ctl[dtc_pkg::CTL_XA_PND];
      o_ext_irq_b_req <= nxt_ctl[dtc_pkg::CTL_XB_PND];
    end
  end

endmodule : dtc_timer_ctrl

// ===== dv/dtc_timer_ctrl_props.sv
// Concurrent checks on the ports of the dual timer control block.
`timescale 1ns/100ps
module dtc_timer_ctrl_props (
  input wire logic                  i_sys_clk,
  input wire logic                  i_rst,
  input wire logic                  i_ce,
  input wire dtc_pkg::dtc_bus_req_t i_bus,
  input wire logic [7:0]            o_rdata,
  input wire logic                  i_ext_irq_a_pin,
  input wire logic                  i_ext_irq_b_pin,
  input wire logic                  i_timer_a_count_pin,
  input wire logic                  i_timer_b_count_pin,
  input wire logic                  i_vector_timer_a,
  input wire logic                  i_vector_timer_b,
  input wire logic                  i_vector_ext_a,
  input wire logic                  i_vector_ext_b,
  input wire logic                  o_timer_a_irq,
  input wire logic                  o_timer_b_irq,
  input wire logic                  o_ext_irq_a_req,
  input wire logic                  o_ext_irq_b_req
);
  // ========
  // Helpers
  // Cycles since a pin was last low; the pins pass a synchroniser, so a
  // pending flag may rise a few cycles after the pin itself went low.
  logic [3:0] since_a_ff;
  logic [3:0] since_b_ff;
  always_ff @(posedge i_sys_clk) begin
    since_a_ff <= !i_ext_irq_a_pin ? 4'h0 : (i_rst || since_a_ff == 4'hf) ? 4'hf : since_a_ff + 4'h1;
  end
  always_ff @(posedge i_sys_clk) begin
    since_b_ff <= !i_ext_irq_b_pin ? 4'h0 : (i_rst || since_b_ff == 4'hf) ? 4'hf : since_b_ff + 4'h1;
  end
  // ========
  // Properties
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_mode_wr;
    i_ce && i_bus.wr && i_bus.addr == dtc_pkg::TIMER_MODE_ADDR;
  endsequence
  sequence s_mode_rd;
    i_ce && i_bus.rd && i_bus.addr == dtc_pkg::TIMER_MODE_ADDR;
  endsequence
  a_reset_quiet:
    assert property ($fell(i_rst) |-> o_rdata == 8'h00 && !o_timer_a_irq && !o_timer_b_irq
      && !o_ext_irq_a_req && !o_ext_irq_b_req) else $error("outputs not cleared by reset");
  a_rdata_idle:
    assert property (i_ce && !i_bus.rd |=> o_rdata == 8'h00) else $error("read data without read");
  a_unmapped_zero:
    assert property (i_ce && i_bus.rd && (i_bus.addr < dtc_pkg::TIMER_CONTROL_ADDR
      || i_bus.addr > dtc_pkg::TIMER_B_HIGH_ADDR) |=> o_rdata == 8'h00) else $error("unmapped read not zero");
  a_mode_echo:
    assert property (s_mode_wr ##1 s_mode_rd |=> o_rdata == $past(i_bus.wdata, 2))
      else $error("mode readback differs");
  a_flag_a_cause:
    assert property ($fell(o_timer_a_irq) |-> $past(i_vector_timer_a || i_bus.wr))
      else $error("timer a flag fell without cause");
  a_flag_b_cause:
    assert property ($fell(o_timer_b_irq) |-> $past(i_vector_timer_b || i_bus.wr))
      else $error("timer b flag fell without cause");
  a_pend_a_cause:
    assert property ($rose(o_ext_irq_a_req) |-> since_a_ff < 4'h8 || $past(i_bus.wr))
      else $error("pending a rose without pin");
  a_pend_b_cause:
    assert property ($rose(o_ext_irq_b_req) |-> since_b_ff < 4'h8 || $past(i_bus.wr))
      else $error("pending b rose without pin");
endmodule : dtc_timer_ctrl_props

bind dtc_timer_ctrl dtc_timer_ctrl_props u_dtc_timer_ctrl_props (.i_sys_clk, .i_rst, .i_ce, .i_bus, .o_rdata,
  .i_ext_irq_a_pin, .i_ext_irq_b_pin, .i_timer_a_count_pin, .i_timer_b_count_pin, .i_vector_timer_a,
  .i_vector_timer_b, .i_vector_ext_a, .i_vector_ext_b, .o_timer_a_irq, .o_timer_b_irq, .o_ext_irq_a_req,
  .o_ext_irq_b_req);

// ===== dv/dtc_pins_model.sv
// Model of the external interrupt and count pins facing the timer block.
`timescale 1ns/100ps
module dtc_pins_model (
  input  wire logic       i_clk,
  output logic      [3:0] o_pins
);
  // ========
  // Pin drive
  // The pins rest high, as the pull-ups on the board would hold them.
  initial o_pins = 4'hf;
  task automatic set_pin(input int k, input logic v);
    @(posedge i_clk);
    o_pins[k] <= v;
  endtask : set_pin
  task automatic fall(input int k);
    set_pin(k, 1'b0);
    repeat (4) @(posedge i_clk);
    o_pins[k] <= 1'b1;
  endtask : fall
endmodule : dtc_pins_model

// ===== dv/dtc_timer_ctrl_tb_top.sv
// Self-checking bench for the dual timer control block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module dtc_timer_ctrl_tb_top;
  logic                  i_sys_clk;
  logic                  i_rst;
  logic                  i_ce;
  dtc_pkg::dtc_bus_req_t i_bus;
  logic [7:0]            o_rdata;
  wire logic             i_ext_irq_a_pin;
  wire logic             i_ext_irq_b_pin;
  wire logic             i_timer_a_count_pin;
  wire logic             i_timer_b_count_pin;
  logic                  i_vector_timer_a;
  logic                  i_vector_timer_b;
  logic                  i_vector_ext_a;
  logic                  i_vector_ext_b;
  logic                  o_timer_a_irq;
  logic                  o_timer_b_irq;
  logic                  o_ext_irq_a_req;
  logic                  o_ext_irq_b_req;
  int                    failures;
  int                    samples_checked;
  logic                  s;
  wire logic [3:0]       irqs = {o_ext_irq_b_req, o_timer_b_irq, o_ext_irq_a_req, o_timer_a_irq};

  dtc_timer_ctrl u_dtc_timer_ctrl (.i_sys_clk, .i_rst, .i_ce, .i_bus, .o_rdata, .i_ext_irq_a_pin,
    .i_ext_irq_b_pin, .i_timer_a_count_pin, .i_timer_b_count_pin, .i_vector_timer_a, .i_vector_timer_b,
    .i_vector_ext_a, .i_vector_ext_b, .o_timer_a_irq, .o_timer_b_irq, .o_ext_irq_a_req, .o_ext_irq_b_req);
  dtc_pins_model u_dtc_pins_model (.i_clk(i_sys_clk),
    .o_pins({i_timer_b_count_pin, i_timer_a_count_pin, i_ext_irq_b_pin, i_ext_irq_a_pin}));

  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // ========
  // Bus and helper tasks
  // A write leaves its strobe up; the next task either replaces it at the next
  // edge or idles the bus, so no count byte is rewritten by accident.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
  endtask : wr
  task automatic chk_rd(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_sys_clk);
    i_bus <= '0;
    @(negedge i_sys_clk);
    `CHK(n, e, o_rdata)
  endtask : chk_rd
  task automatic wait_irq(input int k, input int n);
    @(posedge i_sys_clk);
    i_bus <= '0;
    s = 1'b0;
    repeat (n) begin
      @(negedge i_sys_clk);
      if (irqs[k] === 1'b1) s = 1'b1;
    end
  endtask : wait_irq
  task automatic vec(input int k);
    @(posedge i_sys_clk);
    {i_vector_ext_b, i_vector_ext_a, i_vector_timer_b, i_vector_timer_a} <= 4'h1 << k;
    @(posedge i_sys_clk);
    {i_vector_ext_b, i_vector_ext_a, i_vector_timer_b, i_vector_timer_a} <= 4'h0;
    @(negedge i_sys_clk);
  endtask : vec
  task automatic rst_dut();
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    i_bus <= '0;
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
  endtask : rst_dut
  task automatic setup(input logic [7:0] md, input logic b, input logic [7:0] lo, input logic [7:0] hi);
    wr(dtc_pkg::TIMER_MODE_ADDR, md);
    wr(b ? dtc_pkg::TIMER_B_LOW_ADDR : dtc_pkg::TIMER_A_LOW_ADDR, lo);
    wr(b ? dtc_pkg::TIMER_B_HIGH_ADDR : dtc_pkg::TIMER_A_HIGH_ADDR, hi);
  endtask : setup
  // ========
  // Scenarios
  task automatic t_regs();
    rst_dut();
    chk_rd("ctl rst", dtc_pkg::TIMER_CONTROL_ADDR, 8'h00);
    chk_rd("mode rst", dtc_pkg::TIMER_MODE_ADDR, 8'h00);
    chk_rd("unmapped", 8'h80, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(dtc_pkg::TIMER_MODE_ADDR, 8'(m) * 8'h11);
      chk_rd("mode", dtc_pkg::TIMER_MODE_ADDR, 8'(m) * 8'h11);
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_timer_a();
    rst_dut();
    setup(8'h01, 1'b0, 8'hff, 8'hff);
    wait_irq(0, 30);
    `CHK("a stopped", 1'b0, s)
    wr(dtc_pkg::TIMER_CONTROL_ADDR, 8'h10);
    wait_irq(0, 14);
    `CHK("a ovf", 1'b1, s)
    chk_rd("ctl", dtc_pkg::TIMER_CONTROL_ADDR, 8'h30);
    chk_rd("a high", dtc_pkg::TIMER_A_HIGH_ADDR, 8'h00);
    vec(0);
    `CHK("a clr", 1'b0, irqs[0])
    $display("test timer_a done");
  endtask : t_timer_a
  task automatic t_timer_b();
    rst_dut();
    // A reload value of all ones keeps the low byte fixed however many ticks pass.
    setup(8'h20, 1'b1, 8'hff, 8'hff);
    wr(dtc_pkg::TIMER_A_LOW_ADDR, 8'h1f);
    wr(dtc_pkg::TIMER_CONTROL_ADDR, 8'h50);
    wait_irq(2, 14);
    `CHK("b ovf", 1'b1, s)
    chk_rd("b reload", dtc_pkg::TIMER_B_LOW_ADDR, 8'hff);
    chk_rd("a prescale", dtc_pkg::TIMER_A_HIGH_ADDR, 8'h01);
    chk_rd("ctl", dtc_pkg::TIMER_CONTROL_ADDR, 8'hd0);
    $display("test timer_b done");
  endtask : t_timer_b
  task automatic t_count_halt();
    rst_dut();
    setup(8'h35, 1'b0, 8'hff, 8'hff);
    wr(dtc_pkg::TIMER_B_LOW_ADDR, 8'hff);
    wr(dtc_pkg::TIMER_B_HIGH_ADDR, 8'hff);
    wr(dtc_pkg::TIMER_CONTROL_ADDR, 8'h50);
    wait_irq(0, 30);
    `CHK("a no edge", 1'b0, s)
    `CHK("b halted", 1'b0, irqs[2])
    u_dtc_pins_model.fall(2);
    wait_irq(0, 14);
    `CHK("a edge", 1'b1, s)
    chk_rd("b held", dtc_pkg::TIMER_B_LOW_ADDR, 8'hff);
    $display("test count_halt done");
  endtask : t_count_halt
  task automatic t_ext();
    rst_dut();
    wr(dtc_pkg::TIMER_CONTROL_ADDR, 8'h05);
    chk_rd("ctl", dtc_pkg::TIMER_CONTROL_ADDR, 8'h05);
    u_dtc_pins_model.fall(0);
    wait_irq(1, 14);
    `CHK("a pend", 1'b1, s)
    vec(2);
    `CHK("a pend clr", 1'b0, irqs[1])
    u_dtc_pins_model.fall(1);
    wait_irq(3, 14);
    `CHK("b pend", 1'b1, s)
    vec(3);
    `CHK("b pend clr", 1'b0, irqs[3])
    $display("test ext done");
  endtask : t_ext
  task automatic t_gate();
    rst_dut();
    u_dtc_pins_model.set_pin(0, 1'b0);
    setup(8'h09, 1'b0, 8'hff, 8'hff);
    wr(dtc_pkg::TIMER_CONTROL_ADDR, 8'h10);
    wait_irq(0, 30);
    `CHK("a gated", 1'b0, s)
    `CHK("a level", 1'b1, irqs[1])
    vec(2);
    repeat (2) @(negedge i_sys_clk);
    `CHK("a level kept", 1'b1, irqs[1])
    u_dtc_pins_model.set_pin(0, 1'b1);
    wait_irq(0, 20);
    `CHK("a ungated", 1'b1, s)
    $display("test gate done");
  endtask : t_gate
  task automatic t_split();
    rst_dut();
    setup(8'h03, 1'b0, 8'hff, 8'hff);
    wr(dtc_pkg::TIMER_CONTROL_ADDR, 8'h10);
    wait_irq(0, 14);
    `CHK("split lo ovf", 1'b1, s)
    `CHK("split hi idle", 1'b0, irqs[2])
    chk_rd("split hi held", dtc_pkg::TIMER_A_HIGH_ADDR, 8'hff);
    wr(dtc_pkg::TIMER_CONTROL_ADDR, 8'h50);
    wait_irq(2, 14);
    `CHK("split hi ovf", 1'b1, s)
    $display("test split done");
  endtask : t_split
  task automatic t_b_gate();
    rst_dut();
    u_dtc_pins_model.set_pin(1, 1'b0);
    setup(8'h92, 1'b1, 8'hff, 8'hff);
    wr(dtc_pkg::TIMER_A_HIGH_ADDR, 8'hff);
    wr(dtc_pkg::TIMER_A_LOW_ADDR, 8'hff);
    wr(dtc_pkg::TIMER_CONTROL_ADDR, 8'h50);
    wait_irq(2, 30);
    `CHK("b gated", 1'b0, s)
    chk_rd("a reload", dtc_pkg::TIMER_A_LOW_ADDR, 8'hff);
    u_dtc_pins_model.set_pin(1, 1'b1);
    wait_irq(2, 20);
    `CHK("b ungated", 1'b1, s)
    wr(dtc_pkg::TIMER_CONTROL_ADDR, 8'h10);
    wr(dtc_pkg::TIMER_B_LOW_ADDR, 8'hff);
    wr(dtc_pkg::TIMER_B_HIGH_ADDR, 8'hff);
    wait_irq(2, 30);
    `CHK("b stopped", 1'b0, s)
    $display("test b_gate done");
  endtask : t_b_gate
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // ========
  // Main sequence and watchdog
  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_bus = '0;
    {i_vector_ext_b, i_vector_ext_a, i_vector_timer_b, i_vector_timer_a} = 4'h0;
    failures = 0;
    samples_checked = 0;
    t_regs();
    t_timer_a();
    t_timer_b();
    t_count_halt();
    t_ext();
    t_gate();
    t_split();
    t_b_gate();
    tally_and_finish();
  end
  initial begin
    repeat (6000) @(posedge i_sys_clk);
    failures++;
    tally_and_finish();
  end
endmodule : dtc_timer_ctrl_tb_top
